// ---- hw/ccr_pkg.sv ----
// shared constants and types for the core register, flag and stack block
package ccr_pkg;
    localparam int unsigned NUM_WREGS = 32;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned WIDX_W = 5;
    localparam logic [4:0] PTR_X_LO = 5'h1a;
    localparam logic [4:0] PTR_Y_LO = 5'h1c;
    localparam logic [4:0] PTR_Z_LO = 5'h1e;
    localparam logic [5:0] IO_ADDR_SPL = 6'h3d;
    localparam logic [5:0] IO_ADDR_SPH = 6'h3e;
    localparam logic [5:0] IO_ADDR_FLAGS = 6'h3f;
    localparam logic [15:0] DS_IO_BASE = 16'h0020;
    localparam logic [15:0] DS_EXT_BASE = 16'h0060;
    localparam logic [15:0] DS_EXT_END = 16'h00ff;
    localparam logic [7:0] SPL_RESET = 8'h00;
    localparam logic [7:0] SPH_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam int unsigned FLAG_I = 7;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_C = 0;
    localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
    localparam logic [15:0] SP_STEP_ADDR = 16'h0002;

    typedef enum logic [3:0] {
        CCR_ALU_NOP, CCR_ALU_ADD, CCR_ALU_ADC, CCR_ALU_SUB, CCR_ALU_SBC,
        CCR_ALU_AND, CCR_ALU_OR, CCR_ALU_XOR, CCR_ALU_MOV, CCR_ALU_ADIW,
        CCR_ALU_SBIW, CCR_ALU_MOVW
    } ccr_alu_op_t;

    typedef enum logic [2:0] {
        CCR_SP_HOLD, CCR_SP_PUSH1, CCR_SP_PUSH2, CCR_SP_POP1, CCR_SP_POP2
    } ccr_sp_op_t;

    typedef enum logic [1:0] {
        CCR_PTR_DISP, CCR_PTR_POSTINC, CCR_PTR_PREDEC
    } ccr_ptr_mode_t;

    typedef enum logic [1:0] {
        CCR_I_KEEP, CCR_I_SET, CCR_I_CLR
    } ccr_gie_op_t;

    typedef enum logic [1:0] {
        CCR_ACC_NONE, CCR_ACC_IO, CCR_ACC_DS
    } ccr_acc_kind_t;

    // one decoded instruction from the sequencer
    typedef struct packed {
        ccr_alu_op_t alu_op;
        logic [4:0] dst;
        logic [4:0] src;
        logic use_imm;
        logic [7:0] imm;
        ccr_sp_op_t sp_op;
        ccr_gie_op_t gie_op;
        logic bit_store_instr;
        logic bit_load_instr;
        logic [2:0] bit_sel;
    } ccr_cmd_t;

    // data memory style access from the load/store and io units
    typedef struct packed {
        ccr_acc_kind_t kind;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ccr_mem_req_t;

    // pointer based access request
    typedef struct packed {
        logic valid;
        logic [1:0] sel;
        ccr_ptr_mode_t mode;
        logic [5:0] disp;
    } ccr_ptr_req_t;
endpackage

// ---- hw/ccr_regmem.sv ----
// 32 x 8 working register array, two read ports, 8 or 16 bit write
module ccr_regmem #(
    parameter int unsigned DEPTH = 32,
    parameter int unsigned WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic [4:0] ra_i,
    input wire logic [4:0] rb_i,
    output logic [WIDTH-1:0] rda_o,
    output logic [WIDTH-1:0] rdb_o,
    output logic [2*WIDTH-1:0] rpair_o,
    input wire logic we_i,
    input wire logic we16_i,
    input wire logic [4:0] wa_i,
    input wire logic [2*WIDTH-1:0] wd_i
);
    initial begin
        if (DEPTH != 32 || WIDTH < 1) $error("ccr_regmem: unsupported size");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    wire logic [4:0] wa_hi = {wa_i[4:1], 1'b1};
    wire logic [4:0] wa_lo = {wa_i[4:1], 1'b0};
    wire logic [4:0] ra_hi = {ra_i[4:1], 1'b1};
    wire logic [4:0] ra_lo = {ra_i[4:1], 1'b0};

    // combinational read keeps read-modify-write inside one cycle
    assign rda_o = mem[ra_i];
    assign rdb_o = mem[rb_i];
    assign rpair_o = {mem[ra_hi], mem[ra_lo]};

    always_ff @(posedge clk_i) begin
        if (we16_i) begin
            mem[wa_lo] <= wd_i[WIDTH-1:0];
            mem[wa_hi] <= wd_i[2*WIDTH-1:WIDTH];
        end else if (we_i) begin
            mem[wa_i] <= wd_i[WIDTH-1:0];
        end
    end
endmodule

// ---- hw/ccr_alu.sv ----
// single cycle alu with flag generation
module ccr_alu
    import ccr_pkg::*;
(
    input wire ccr_pkg::ccr_alu_op_t op_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic [15:0] w_i,
    input wire logic [7:0] flags_i,
    output logic [15:0] res_o,
    output logic wide_o,
    output logic [7:0] flags_o
);
    logic [8:0] sum;
    logic [16:0] wsum;
    logic h;
    logic v;
    logic n;
    logic c;
    logic zf;
    logic upd_h;
    always_comb begin
        sum = 9'h000;
        wsum = 17'h00000;
        h = flags_i[FLAG_H];
        v = flags_i[FLAG_V];
        c = flags_i[FLAG_C];
        upd_h = 1'b0;
        wide_o = 1'b0;
        res_o = 16'h0000;
        unique case (op_i)
            CCR_ALU_ADD, CCR_ALU_ADC: begin
                sum = {1'b0, a_i} + {1'b0, b_i}
                    + {8'h00, (op_i == CCR_ALU_ADC) & flags_i[FLAG_C]};
                c = sum[8];
                v = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
                h = (a_i[3] & b_i[3]) | (b_i[3] & ~sum[3]) | (~sum[3] & a_i[3]);
                upd_h = 1'b1;
                res_o = {8'h00, sum[7:0]};
            end
            CCR_ALU_SUB, CCR_ALU_SBC: begin
                sum = {1'b0, a_i} - {1'b0, b_i}
                    - {8'h00, (op_i == CCR_ALU_SBC) & flags_i[FLAG_C]};
                c = sum[8];
                v = (a_i[7] != b_i[7]) && (sum[7] != a_i[7]);
                h = (~a_i[3] & b_i[3]) | (b_i[3] & sum[3]) | (sum[3] & ~a_i[3]);
                upd_h = 1'b1;
                res_o = {8'h00, sum[7:0]};
            end
            CCR_ALU_AND: begin
                res_o = {8'h00, a_i & b_i};
                v = 1'b0;
            end
            CCR_ALU_OR: begin
                res_o = {8'h00, a_i | b_i};
                v = 1'b0;
            end
            CCR_ALU_XOR: begin
                res_o = {8'h00, a_i ^ b_i};
                v = 1'b0;
            end
            CCR_ALU_MOV: res_o = {8'h00, b_i};
            CCR_ALU_ADIW, CCR_ALU_SBIW: begin
                wsum = (op_i == CCR_ALU_ADIW) ? {1'b0, w_i} + {9'h000, b_i}
                                              : {1'b0, w_i} - {9'h000, b_i};
                c = wsum[16];
                v = (op_i == CCR_ALU_ADIW) ? (~w_i[15] & wsum[15])
                                           : (w_i[15] & ~wsum[15]);
                wide_o = 1'b1;
                res_o = wsum[15:0];
            end
            CCR_ALU_MOVW: begin
                wide_o = 1'b1;
                res_o = w_i;
            end
            CCR_ALU_NOP: res_o = 16'h0000;
            default: res_o = 16'h0000;
        endcase
        n = wide_o ? res_o[15] : res_o[7];
        zf = wide_o ? (res_o == 16'h0000) : (res_o[7:0] == 8'h00);
        flags_o = flags_i;
        if (op_i != CCR_ALU_NOP && op_i != CCR_ALU_MOV && op_i != CCR_ALU_MOVW) begin
            flags_o[FLAG_H] = upd_h ? h : flags_i[FLAG_H]; // RULE_13
            flags_o[FLAG_V] = v; // RULE_15
            flags_o[FLAG_N] = n; // RULE_16
            flags_o[FLAG_Z] = zf; // RULE_16
            flags_o[FLAG_C] = (op_i == CCR_ALU_AND || op_i == CCR_ALU_OR
                || op_i == CCR_ALU_XOR) ? flags_i[FLAG_C] : c; // RULE_16
            flags_o[FLAG_S] = n ^ v; // RULE_14
        end
    end
endmodule

// ---- hw/ccr_core.sv ----
// core architectural state: working registers, condition flags, stack pointer
// Function
// [RULE_01] thirty-two 8-bit working registers, any read or written in one cycle
// [RULE_02] two operands read, computed and written back in one cycle
// [RULE_03] next instruction word fetched while the current one executes
// [RULE_04] register file ports: 8r/8w, 2x8r/8w, 2x8r/16w, 16r/16w
// [RULE_05] working registers appear at the lowest 32 data addresses
// [RULE_06] top six registers form three 16-bit pointers; third also addresses flash
// [RULE_07] pointer access supports displacement, post-increment and pre-decrement
// [RULE_08] condition flags updated after every alu operation; the code leaves them unchanged for MOV and MOVW
// [RULE_09] flags are neither saved on interrupt entry nor restored on return
// [RULE_10] bit 7 global enable gates every interrupt
// [RULE_11] global enable cleared on interrupt, set by return, set/cleared by instructions
// [RULE_12] bit 6 is a one-bit store for bit-store and bit-load instructions
// [RULE_13] bit 5 records half carry from the low nibble
// [RULE_14] bit 4 sign equals negative xor overflow
// [RULE_15] bit 3 signals two's complement overflow
// [RULE_16] bit 2 negative, bit 1 zero, bit 0 carry
// [RULE_17] stack grows downward; push lowers the pointer
// [RULE_18] pointer -1 byte push, -2 call/irq, +1 byte pop, +2 returns
// [RULE_19] software sets the stack pointer above the io region before use
// [RULE_20] stack pointer is two rw bytes at io 0x3e and 0x3d, reset zero
// [RULE_21] 64 io addresses, also at data addresses 0x20 to 0x5f
// [RULE_22] extended io 0x60 to 0xff only by data load/store, not direct io
// [RULE_23] reset clears every flag including the global enable
module ccr_core
    import ccr_pkg::*;
#(
    parameter int unsigned NREGS = 32,
    parameter int unsigned PC_W = 16
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic cmd_valid_i,
    input wire ccr_pkg::ccr_cmd_t cmd_i,
    input wire logic irq_take_i,
    input wire logic irq_return_i,
    input wire logic irq_pending_i,
    input wire logic [15:0] fetch_word_i,
    input wire logic fetch_en_i,
    input wire ccr_pkg::ccr_mem_req_t mem_req_i,
    input wire ccr_pkg::ccr_ptr_req_t ptr_req_i,
    output logic [15:0] instr_reg_o,
    output logic [7:0] rdata_o,
    output logic [7:0] ext_rdata_o,
    output logic ext_hit_o,
    output logic [15:0] ptr_addr_o,
    output logic [15:0] flash_addr_o,
    output logic irq_accept_o,
    output logic [7:0] flags_o,
    output logic [15:0] stack_top_pointer_o
);
    import ccr_pkg::*;
    initial begin
        if (NREGS != NUM_WREGS) $error("ccr_core: register count must be 32");
        if (PC_W != 16) $error("ccr_core: pointer width must be 16");
    end

    logic [7:0] condition_flags_reg;
    logic [7:0] condition_flags_next;
    logic [7:0] stack_ptr_low_byte_reg;
    logic [7:0] stack_ptr_high_byte_reg;
    logic [15:0] sp_next;
    logic [15:0] instr_reg;
    logic [7:0] rdata_reg;
    logic [7:0] ext_rdata_reg;
    logic ext_hit_reg;
    logic [15:0] ptr_addr_reg;
    logic [15:0] flash_addr_reg;
    logic irq_accept_reg;

    function automatic logic [4:0] ptr_base(input logic [1:0] sel);
        unique case (sel)
            2'd0: ptr_base = PTR_X_LO;
            2'd1: ptr_base = PTR_Y_LO;
            default: ptr_base = PTR_Z_LO;
        endcase
    endfunction

    function automatic logic is_wreg(input logic [15:0] a);
        is_wreg = a < DS_IO_BASE;
    endfunction

    function automatic logic is_io(input logic [15:0] a);
        is_io = (a >= DS_IO_BASE) && (a < DS_EXT_BASE);
    endfunction

    // decode of the memory-style access
    wire logic io_acc = mem_req_i.kind == CCR_ACC_IO;
    wire logic ds_acc = mem_req_i.kind == CCR_ACC_DS;
    wire logic [5:0] io_idx = io_acc ? mem_req_i.addr[5:0]
                                     : 6'(mem_req_i.addr - DS_IO_BASE); // RULE_21
    wire logic hit_io = io_acc || (ds_acc && is_io(mem_req_i.addr)); // RULE_21
    wire logic hit_wreg = ds_acc && is_wreg(mem_req_i.addr); // RULE_05
    // direct io codes reach only six address bits, so 0x60 up stays data-only
    wire logic hit_ext = ds_acc && (mem_req_i.addr >= DS_EXT_BASE)
                      && (mem_req_i.addr <= DS_EXT_END); // RULE_22
    wire logic wr_spl = hit_io && mem_req_i.wr && io_idx == IO_ADDR_SPL; // RULE_20
    wire logic wr_sph = hit_io && mem_req_i.wr && io_idx == IO_ADDR_SPH; // RULE_20
    wire logic wr_flags = hit_io && mem_req_i.wr && io_idx == IO_ADDR_FLAGS;
    wire logic [7:0] io_rd = (io_idx == IO_ADDR_SPL) ? stack_ptr_low_byte_reg
                           : (io_idx == IO_ADDR_SPH) ? stack_ptr_high_byte_reg
                           : (io_idx == IO_ADDR_FLAGS) ? condition_flags_reg : 8'h00;

    // pointer datapath
    wire logic [4:0] pbase = ptr_base(ptr_req_i.sel); // RULE_06
    logic [15:0] ptr_val;
    wire logic [15:0] ptr_dec = ptr_val - 16'h0001;
    wire logic [15:0] ptr_inc = ptr_val + 16'h0001;
    wire logic [15:0] ptr_eff = (ptr_req_i.mode == CCR_PTR_PREDEC) ? ptr_dec
                              : (ptr_req_i.mode == CCR_PTR_DISP)
                                ? ptr_val + {10'h000, ptr_req_i.disp} : ptr_val; // RULE_07
    wire logic ptr_upd = ptr_req_i.valid && ptr_req_i.mode != CCR_PTR_DISP;
    wire logic [15:0] ptr_wb = (ptr_req_i.mode == CCR_PTR_PREDEC) ? ptr_dec : ptr_inc;

    // register file ports
    wire logic exec = cmd_valid_i;
    wire logic [4:0] ra = ptr_req_i.valid ? pbase
                        : (hit_wreg ? mem_req_i.addr[4:0] : cmd_i.dst);
    logic [7:0] rda;
    logic [7:0] rdb;
    logic [15:0] rpair;
    logic [15:0] alu_res;
    logic alu_wide;
    logic [7:0] alu_flags;
    assign ptr_val = rpair;
    wire logic [7:0] opb = cmd_i.use_imm ? cmd_i.imm : rdb;
    wire logic [15:0] wsrc = (cmd_i.alu_op == CCR_ALU_MOVW) ? {rdb, rdb} : rpair;

    ccr_alu u_alu (
        .op_i(exec ? cmd_i.alu_op : CCR_ALU_NOP),
        .a_i(rda),
        .b_i(opb),
        .w_i(wsrc),
        .flags_i(condition_flags_reg),
        .res_o(alu_res),
        .wide_o(alu_wide),
        .flags_o(alu_flags)
    );

    wire logic [7:0] bld_val = (rda & ~(8'h01 << cmd_i.bit_sel))
                             | ({7'h00, condition_flags_reg[FLAG_T]} << cmd_i.bit_sel); // RULE_12
    wire logic alu_wr = exec && cmd_i.alu_op != CCR_ALU_NOP;
    wire logic bld_wr = exec && cmd_i.bit_load_instr;
    wire logic mem_wr = hit_wreg && mem_req_i.wr; // RULE_05
    wire logic we8 = ptr_upd ? 1'b0 : (mem_wr || bld_wr || (alu_wr && !alu_wide));
    wire logic we16 = ptr_upd || (alu_wr && alu_wide); // RULE_04
    wire logic [4:0] wa = ptr_upd ? pbase : (mem_wr ? mem_req_i.addr[4:0] : cmd_i.dst);
    wire logic [15:0] wd = ptr_upd ? ptr_wb
                         : mem_wr ? {8'h00, mem_req_i.wdata}
                         : bld_wr ? {8'h00, bld_val} : alu_res; // RULE_02

    ccr_regmem #(.DEPTH(NUM_WREGS), .WIDTH(DATA_W)) u_regs ( // RULE_01 RULE_04
        .clk_i(clk_i),
        .ra_i(ra),
        .rb_i(cmd_i.src),
        .rda_o(rda),
        .rdb_o(rdb),
        .rpair_o(rpair),
        .we_i(we8),
        .we16_i(we16),
        .wa_i(wa),
        .wd_i(wd)
    );

    // flag next state; the interrupt path never saves or restores flags
    always_comb begin
        condition_flags_next = alu_flags; // RULE_08 RULE_09
        if (exec && cmd_i.bit_store_instr)
            condition_flags_next[FLAG_T] = rda[cmd_i.bit_sel]; // RULE_12
        if (wr_flags)
            condition_flags_next = mem_req_i.wdata;
        if (exec && cmd_i.gie_op == CCR_I_SET)
            condition_flags_next[FLAG_I] = 1'b1; // RULE_11
        if (exec && cmd_i.gie_op == CCR_I_CLR)
            condition_flags_next[FLAG_I] = 1'b0; // RULE_11
        if (irq_return_i)
            condition_flags_next[FLAG_I] = 1'b1; // RULE_11
        if (irq_take_i && condition_flags_reg[FLAG_I])
            condition_flags_next[FLAG_I] = 1'b0; // RULE_11
    end

    // stack pointer arithmetic, push lowers
    wire logic [15:0] sp_cur = {stack_ptr_high_byte_reg, stack_ptr_low_byte_reg};
    wire ccr_sp_op_t sp_op = (irq_take_i && condition_flags_reg[FLAG_I]) ? CCR_SP_PUSH2
                           : irq_return_i ? CCR_SP_POP2
                           : exec ? cmd_i.sp_op : CCR_SP_HOLD;
    always_comb begin
        unique case (sp_op)
            CCR_SP_PUSH1: sp_next = sp_cur - SP_STEP_BYTE; // RULE_17 RULE_18
            CCR_SP_PUSH2: sp_next = sp_cur - SP_STEP_ADDR; // RULE_18
            CCR_SP_POP1: sp_next = sp_cur + SP_STEP_BYTE; // RULE_18
            CCR_SP_POP2: sp_next = sp_cur + SP_STEP_ADDR; // RULE_18
            CCR_SP_HOLD: sp_next = sp_cur;
            default: sp_next = sp_cur;
        endcase
        if (wr_spl)
            sp_next[7:0] = mem_req_i.wdata; // RULE_20
        if (wr_sph)
            sp_next[15:8] = mem_req_i.wdata; // RULE_20
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            condition_flags_reg <= FLAGS_RESET; // RULE_23
            stack_ptr_low_byte_reg <= SPL_RESET; // RULE_20
            stack_ptr_high_byte_reg <= SPH_RESET;
        end else begin
            condition_flags_reg <= condition_flags_next;
            stack_ptr_low_byte_reg <= sp_next[7:0];
            stack_ptr_high_byte_reg <= sp_next[15:8];
        end
    end

    // fetch register loads the next word while this one executes
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            instr_reg <= 16'h0000;
        end else if (fetch_en_i) begin
            instr_reg <= fetch_word_i; // RULE_03
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 8'h00;
            ext_rdata_reg <= 8'h00;
            ext_hit_reg <= 1'b0;
            ptr_addr_reg <= 16'h0000;
            flash_addr_reg <= 16'h0000;
            irq_accept_reg <= 1'b0;
        end else begin
            rdata_reg <= hit_wreg ? rda : (hit_io ? io_rd : 8'h00); // RULE_05 RULE_21
            ext_rdata_reg <= hit_ext ? mem_req_i.wdata : 8'h00;
            ext_hit_reg <= hit_ext; // RULE_22
            ptr_addr_reg <= ptr_req_i.valid ? ptr_eff : ptr_addr_reg; // RULE_07
            flash_addr_reg <= (ptr_req_i.valid && ptr_req_i.sel == 2'd2)
                              ? ptr_eff : flash_addr_reg; // RULE_06
            irq_accept_reg <= irq_pending_i && condition_flags_reg[FLAG_I]; // RULE_10
        end
    end

    assign instr_reg_o = instr_reg;
    assign rdata_o = rdata_reg;
    assign ext_rdata_o = ext_rdata_reg;
    assign ext_hit_o = ext_hit_reg;
    assign ptr_addr_o = ptr_addr_reg;
    assign flash_addr_o = flash_addr_reg;
    assign irq_accept_o = irq_accept_reg;
    assign flags_o = condition_flags_reg;
    assign stack_top_pointer_o = {stack_ptr_high_byte_reg, stack_ptr_low_byte_reg};

    property p_sign_xor;
        @(posedge clk_i) disable iff (sys_rst_i)
        exec && cmd_i.alu_op inside {CCR_ALU_ADD, CCR_ALU_SUB} && !wr_flags
        |=> flags_o[FLAG_S] == (flags_o[FLAG_N] ^ flags_o[FLAG_V]);
    endproperty
    a_sign_xor: assert property (p_sign_xor) else $error("sign not n xor v"); // RULE_14

    property p_gie_gate;
        @(posedge clk_i) disable iff (sys_rst_i)
        !flags_o[FLAG_I] |=> !irq_accept_o;
    endproperty
    a_gie_gate: assert property (p_gie_gate) else $error("irq accepted while disabled"); // RULE_10

    property p_push1;
        @(posedge clk_i) disable iff (sys_rst_i)
        sp_op == CCR_SP_PUSH1 && !wr_spl && !wr_sph
        |=> stack_top_pointer_o == $past(stack_top_pointer_o) - 16'h0001;
    endproperty
    a_push1: assert property (p_push1) else $error("byte push step wrong"); // RULE_18

    property p_call_push;
        @(posedge clk_i) disable iff (sys_rst_i)
        irq_take_i && flags_o[FLAG_I] && !wr_spl && !wr_sph
        |=> stack_top_pointer_o == $past(stack_top_pointer_o) - 16'h0002 && !flags_o[FLAG_I];
    endproperty
    a_call_push: assert property (p_call_push) else $error("irq entry wrong"); // RULE_11

    property p_ret_pop;
        @(posedge clk_i) disable iff (sys_rst_i)
        irq_return_i && !(irq_take_i && flags_o[FLAG_I]) && !wr_spl && !wr_sph
        |=> stack_top_pointer_o == $past(stack_top_pointer_o) + 16'h0002 && flags_o[FLAG_I];
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("irq return wrong"); // RULE_18

    sequence s_rst;
        sys_rst_i;
    endsequence
    property p_reset_clear;
        @(posedge clk_i) s_rst |=> flags_o == 8'h00 && stack_top_pointer_o == 16'h0000;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong"); // RULE_23

    property p_zero_flag;
        @(posedge clk_i) disable iff (sys_rst_i)
        exec && cmd_i.alu_op == CCR_ALU_XOR && rda == opb && !wr_flags
        |=> flags_o[FLAG_Z] && !flags_o[FLAG_N];
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong"); // RULE_16

    property p_bst;
        @(posedge clk_i) disable iff (sys_rst_i)
        exec && cmd_i.bit_store_instr && !wr_flags |=> flags_o[FLAG_T] == $past(rda[cmd_i.bit_sel]);
    endproperty
    a_bst: assert property (p_bst) else $error("bit store wrong"); // RULE_12

    property p_flash_z;
        @(posedge clk_i) disable iff (sys_rst_i)
        ptr_req_i.valid && ptr_req_i.sel == 2'd2
        |=> flash_addr_o == ptr_addr_o;
    endproperty
    a_flash_z: assert property (p_flash_z) else $error("flash pointer wrong"); // RULE_06

    property p_predec;
        @(posedge clk_i) disable iff (sys_rst_i)
        ptr_req_i.valid && ptr_req_i.mode == CCR_PTR_PREDEC
        |=> ptr_addr_o == $past(rpair) - 16'h0001;
    endproperty
    a_predec: assert property (p_predec) else $error("pre-decrement wrong"); // RULE_07

    property p_cli;
        @(posedge clk_i) disable iff (sys_rst_i)
        exec && cmd_i.gie_op == CCR_I_CLR && !irq_return_i
        |=> !flags_o[FLAG_I];
    endproperty
    a_cli: assert property (p_cli) else $error("disable-all failed"); // RULE_11

    property p_io_not_ext;
        @(posedge clk_i) disable iff (sys_rst_i)
        mem_req_i.kind == CCR_ACC_IO
        |=> !ext_hit_o;
    endproperty
    a_io_not_ext: assert property (p_io_not_ext) else $error("direct io hit ext"); // RULE_22

    property p_pop1;
        @(posedge clk_i) disable iff (sys_rst_i)
        sp_op == CCR_SP_POP1 && !wr_spl && !wr_sph
        |=> stack_top_pointer_o == $past(stack_top_pointer_o) + 16'h0001;
    endproperty
    a_pop1: assert property (p_pop1) else $error("byte pop step wrong"); // RULE_18
endmodule

// ---- dv/ccr_fetch_model.sv ----
// program memory model feeding the core's prefetch port
module ccr_fetch_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    output logic [15:0] fetch_word_o = 16'h0000,
    output logic fetch_en_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // a fresh word every cycle so a stale prefetch register shows at once
    always @(negedge clk_i) begin
        fetch_en_o <= ~sys_rst_i;
        fetch_word_o <= sys_rst_i ? 16'h0000 : fetch_word_o * 16'h0005 + 16'h3c1b;
    end
endmodule

// ---- dv/cpu_core_regs_flags_stack_tb.sv ----
// self-checking bench for the core register, flag and stack block
module cpu_core_regs_flags_stack_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ccr_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cmd_valid_i = 1'b0, irq_take_i = 1'b0, irq_return_i = 1'b0, irq_pending_i = 1'b0;
    ccr_cmd_t cmd_i = '0;
    ccr_mem_req_t mem_req_i = '0;
    ccr_ptr_req_t ptr_req_i = '0;
    logic [15:0] fetch_word, instr_reg_o, ptr_addr_o, flash_addr_o, stack_top_pointer_o;
    logic fetch_en, ext_hit_o, irq_accept_o;
    logic [7:0] rdata_o, ext_rdata_o, flags_o;
    int mismatches = 0, n_compared = 0, sp, a, b, r, fl, w;
    bit v;
    ccr_sp_op_t sops[5] = '{CCR_SP_HOLD, CCR_SP_PUSH1, CCR_SP_PUSH2, CCR_SP_POP1, CCR_SP_POP2};
    int steps[5] = '{0, -1, -2, 1, 2};
    always #2 clk_i = ~clk_i;
    ccr_fetch_model pm (.clk_i, .sys_rst_i, .fetch_word_o(fetch_word), .fetch_en_o(fetch_en));
    ccr_core dut (.clk_i, .sys_rst_i, .cmd_valid_i, .cmd_i, .irq_take_i, .irq_return_i,
        .irq_pending_i, .fetch_word_i(fetch_word), .fetch_en_i(fetch_en), .mem_req_i,
        .ptr_req_i, .instr_reg_o, .rdata_o, .ext_rdata_o, .ext_hit_o, .ptr_addr_o,
        .flash_addr_o, .irq_accept_o, .flags_o, .stack_top_pointer_o);
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic mem(input ccr_acc_kind_t k, input logic wr, input logic [15:0] ad,
        input logic [7:0] wd);
        @(negedge clk_i);
        mem_req_i = '{k, wr, ad, wd};
        @(negedge clk_i);
        mem_req_i = '0;
    endtask
    task automatic exec(input ccr_alu_op_t op, input ccr_sp_op_t so, input ccr_gie_op_t g,
        input bit bs = 1'b0);
        @(negedge clk_i);
        cmd_i = '{op, 5'h01, 5'h02, 1'b0, 8'h00, so, g, bs, 1'b0, 3'h0};
        cmd_valid_i = 1'b1;
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
    endtask
    task automatic pulse(input bit tk);
        @(negedge clk_i);
        irq_take_i = tk;
        irq_return_i = ~tk;
        @(negedge clk_i);
        irq_take_i = 1'b0;
        irq_return_i = 1'b0;
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard at 100000 cycles, far above the length of the run
    initial begin
        #400000;
        mismatches++;
        results();
    end
    initial begin
        void'($urandom(32'h5c77d68e));
        repeat (5) @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk("flags_rst", flags_o, 8'h00);
        chk("sp_rst", stack_top_pointer_o, 16'h0000);
        // software keeps the stack above the io region
        sp = 16'h0100 + ($urandom & 16'h0eff);
        mem(CCR_ACC_IO, 1'b1, 16'h003d, sp[7:0]);
        mem(CCR_ACC_IO, 1'b1, 16'h003e, sp[15:8]);
        chk("sp_wr", stack_top_pointer_o, sp[15:0]);
        foreach (sops[i]) begin
            exec(CCR_ALU_NOP, sops[i], CCR_I_KEEP);
            sp += steps[i];
            chk("sp_step", stack_top_pointer_o, sp[15:0]);
        end
        mem(CCR_ACC_IO, 1'b0, 16'h003e, 8'h00);
        chk("sph_rd", rdata_o, sp[15:8]);
        mem(CCR_ACC_DS, 1'b0, 16'h005d, 8'h00);
        chk("spl_ds", rdata_o, sp[7:0]);
        $display("test stack done");
        repeat (4) begin
            a = $urandom & 255;
            b = $urandom & 255;
            mem(CCR_ACC_DS, 1'b1, 16'h0001, a[7:0]);
            mem(CCR_ACC_DS, 1'b1, 16'h0002, b[7:0]);
            exec(CCR_ALU_ADD, CCR_SP_HOLD, CCR_I_KEEP);
            r = a + b;
            v = (a[7] == b[7]) && (r[7] != a[7]);
            fl = {2'b00, ((a & 15) + (b & 15)) > 15, r[7] ^ v, v, r[7], r[7:0] == 0, r[8]};
            chk("add_flags", flags_o, fl[7:0]);
            mem(CCR_ACC_DS, 1'b0, 16'h0001, 8'h00);
            chk("add_res", rdata_o, r[7:0]);
        end
        mem(CCR_ACC_DS, 1'b1, 16'h0002, r[7:0]);
        exec(CCR_ALU_XOR, CCR_SP_HOLD, CCR_I_KEEP, 1'b1);
        fl = (fl & 8'h21) | 8'h02 | ((r & 1) << 6);
        chk("xor_bst_flags", flags_o, fl[7:0]);
        $display("test alu done");
        pulse(1'b1);
        chk("sp_noirq", stack_top_pointer_o, sp[15:0]);
        exec(CCR_ALU_NOP, CCR_SP_HOLD, CCR_I_SET);
        fl |= 8'h80;
        chk("sei", flags_o, fl[7:0]);
        irq_pending_i = 1'b1;
        @(negedge clk_i);
        irq_pending_i = 1'b0;
        chk("accept", irq_accept_o, 1'b1);
        pulse(1'b1);
        sp -= 2;
        fl &= 8'h7f;
        chk("irq_sp", stack_top_pointer_o, sp[15:0]);
        chk("irq_flags", flags_o, fl[7:0]);
        pulse(1'b0);
        sp += 2;
        fl |= 8'h80;
        chk("ret_sp", stack_top_pointer_o, sp[15:0]);
        chk("ret_flags", flags_o, fl[7:0]);
        exec(CCR_ALU_NOP, CCR_SP_HOLD, CCR_I_CLR);
        chk("cli", flags_o[7], 1'b0);
        $display("test irq done");
        a = $urandom & 8'h7f;
        b = $urandom & 255;
        mem(CCR_ACC_DS, 1'b1, 16'h001a, a[7:0]);
        mem(CCR_ACC_DS, 1'b1, 16'h001b, b[7:0]);
        ptr_req_i = '{1'b1, 2'd0, CCR_PTR_POSTINC, 6'h00};
        @(negedge clk_i);
        ptr_req_i = '0;
        chk("ptr", ptr_addr_o, {b[7:0], a[7:0]});
        mem(CCR_ACC_DS, 1'b0, 16'h001a, 8'h00);
        chk("ptr_inc", rdata_o, a + 1);
        mem(CCR_ACC_DS, 1'b1, 16'h001e, a[7:0] + 8'h01);
        mem(CCR_ACC_DS, 1'b1, 16'h001f, b[7:0]);
        ptr_req_i = '{1'b1, 2'd2, CCR_PTR_PREDEC, 6'h00};
        @(negedge clk_i);
        ptr_req_i = '0;
        chk("zptr", ptr_addr_o, {b[7:0], a[7:0]});
        chk("flash", flash_addr_o, {b[7:0], a[7:0]});
        mem(CCR_ACC_DS, 1'b1, 16'h0080, 8'h5a);
        chk("ext_hit", ext_hit_o, 1'b1);
        chk("ext_data", ext_rdata_o, 8'h5a);
        #1;
        w = fetch_word;
        @(negedge clk_i);
        chk("fetch", instr_reg_o, w[15:0]);
        $display("test pointer done");
        results();
    end
endmodule
